// ### hw/prr_top.sv
// Preset recall remote port: APB registers, group stepping, judgement and alarm
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
module prr_top
  import prr_pkg::*;
#(
  parameter int HOLD = PRR_HOLD_CYCLES,
  parameter int NGRP = PRR_NUM_GROUPS,
  parameter int NPRE = PRR_NUM_PRESETS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_up_input_b,
  input wire logic step_down_input_b,
  input wire logic return_input_b,
  output logic pass_out,
  output logic pass_out_b,
  output logic fail_out,
  output logic fail_out_b,
  output logic alarm_out,
  output logic alarm_oe_b,
  output logic recall_valid,
  output logic [PRR_COND_W-1:0] recall_cond,
  output logic irq
);
  // ==========================================================
  // Register bus
  logic [PRR_IDX_W-1:0] sel_addr_q;
  logic confirmed_q;
  logic [PRR_GRP_W-1:0] act_grp_q;
  logic [PRR_COND_W-1:0] cond_q;
  logic [PRR_IDX_W-1:0] begin_q [NGRP];
  logic [PRR_IDX_W-1:0] end_q [NGRP];
  logic [31:0] ber_q;
  logic [31:0] upper_q;
  logic [31:0] lower_q;
  logic [PRR_NUM_ALARMS-1:0] alarm_src_q;
  logic [PRR_NUM_EV-1:0] irq_st_q;
  logic [PRR_NUM_EV-1:0] irq_en_q;
  logic [PRR_IDX_W-1:0] pos_q;
  prr_state_type state_q;
  logic [PRR_IDX_W-1:0] rd_idx_q;
  logic [PRR_COND_W-1:0] mem_rd;
  logic [PRR_COND_W-1:0] last_rd_q;
  logic wr_acc;
  logic rd_acc;
  logic store_req;
  logic recall_req;
  logic up_fire;
  logic dn_fire;
  logic ret_fire;
  logic [PRR_NUM_EV-1:0] ev;
  logic cancel_ev;
  logic start_rd;
  logic [PRR_IDX_W-1:0] tgt_idx;
  logic [PRR_IDX_W-1:0] g_begin;
  logic [PRR_IDX_W-1:0] g_end;
  logic ctrl_wr;
  logic grp_wr;
  logic clr_wr;
  logic store_ok;
  logic recall_ok;
  logic ev_recall;
  logic ev_cancel;
  logic ev_store;
  logic [PRR_IDX_W-1:0] up_idx;
  logic [PRR_IDX_W-1:0] dn_idx;
  logic ber_ge_upper;
  logic ber_le_lower;
  logic alarm_any;
  logic busy;

  function automatic logic addr_known(input logic [11:0] a);
    return a inside {PRR_ADDR_CTRL, PRR_ADDR_STATUS, PRR_ADDR_COND, PRR_ADDR_RDATA,
                     PRR_ADDR_GROUP, PRR_ADDR_BER, PRR_ADDR_UPPER, PRR_ADDR_LOWER,
                     PRR_ADDR_ALARM, PRR_ADDR_IRQ_ST, PRR_ADDR_IRQ_EN, PRR_ADDR_IRQ_CLR};
  endfunction

  function automatic logic write_hit(input logic acc, input logic [11:0] a,
                                     input logic [11:0] off);
    return acc && (a == off);
  endfunction

  // Zero-wait slave: access phase always completes in one cycle
  assign wr_acc = psel && penable && pwrite && addr_known(paddr);
  // Read word is fetched in setup so that it stands through the access phase
  assign rd_acc = psel && !penable && !pwrite;
  assign ctrl_wr = write_hit(wr_acc, paddr, PRR_ADDR_CTRL);
  assign grp_wr = write_hit(wr_acc, paddr, PRR_ADDR_GROUP);
  assign clr_wr = write_hit(wr_acc, paddr, PRR_ADDR_IRQ_CLR);
  assign store_req = ctrl_wr && pwdata[PRR_CTRL_STORE];
  assign recall_req = ctrl_wr && pwdata[PRR_CTRL_RECALL];
  // Both act only when the same write also confirms the address
  assign store_ok = store_req && pwdata[PRR_CTRL_CONFIRM];
  assign recall_ok = recall_req && pwdata[PRR_CTRL_CONFIRM];

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= PRR_ZERO;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_known(paddr);
      prdata <= PRR_ZERO;
      if (rd_acc) begin
        unique case (paddr)
          PRR_ADDR_CTRL: prdata <= {18'h0_0000, act_grp_q, 2'b00, confirmed_q, sel_addr_q};
          PRR_ADDR_STATUS: prdata <= {23'h00_0000, busy, 1'b0, pos_q};
          PRR_ADDR_COND: prdata <= cond_q;
          PRR_ADDR_RDATA: prdata <= last_rd_q;
          PRR_ADDR_GROUP: prdata <= {9'h000, end_q[act_grp_q], 1'b0, begin_q[act_grp_q],
                                     4'h0, act_grp_q};
          PRR_ADDR_BER: prdata <= ber_q;
          PRR_ADDR_UPPER: prdata <= upper_q;
          PRR_ADDR_LOWER: prdata <= lower_q;
          PRR_ADDR_ALARM: prdata <= {29'h0000_0000, alarm_src_q};
          PRR_ADDR_IRQ_ST: prdata <= {29'h0000_0000, irq_st_q};
          PRR_ADDR_IRQ_EN: prdata <= {29'h0000_0000, irq_en_q};
          default: prdata <= PRR_ZERO;
        endcase
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sel_addr_q <= '0;
      confirmed_q <= 1'b0;
      act_grp_q <= '0;
    end else if (ctrl_wr) begin
      sel_addr_q <= pwdata[PRR_IDX_W-1:0];
      confirmed_q <= pwdata[PRR_CTRL_CONFIRM];
      // An unknown group number leaves the active group as it was
      if (int'(pwdata[PRR_CTRL_GRP_LSB +: PRR_GRP_W]) < NGRP) begin
        act_grp_q <= pwdata[PRR_CTRL_GRP_LSB +: PRR_GRP_W];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cond_q <= PRR_ZERO;
    end else if (write_hit(wr_acc, paddr, PRR_ADDR_COND)) begin
      cond_q <= pwdata;
    end
  end

  // Judgement inputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ber_q <= PRR_ZERO;
      upper_q <= PRR_ZERO;
      lower_q <= PRR_ZERO;
    end else if (wr_acc) begin
      unique case (paddr)
        PRR_ADDR_BER: ber_q <= pwdata;
        PRR_ADDR_UPPER: upper_q <= pwdata;
        PRR_ADDR_LOWER: lower_q <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      alarm_src_q <= '0;
    end else if (write_hit(wr_acc, paddr, PRR_ADDR_ALARM)) begin
      alarm_src_q <= pwdata[PRR_NUM_ALARMS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_en_q <= '0;
    end else if (write_hit(wr_acc, paddr, PRR_ADDR_IRQ_EN)) begin
      irq_en_q <= pwdata[PRR_NUM_EV-1:0];
    end
  end

  // Group table; software keeps end above begin
  genvar gi;
  generate
    for (gi = 0; gi < NGRP; gi++) begin : g_grp
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          begin_q[gi] <= '0;
          end_q[gi] <= '0;
        end else if (grp_wr && (int'(pwdata[PRR_GRP_W-1:0]) == gi)) begin
          begin_q[gi] <= pwdata[PRR_GRP_BEGIN_LSB +: PRR_IDX_W];
          end_q[gi] <= pwdata[PRR_GRP_END_LSB +: PRR_IDX_W];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Remote inputs, active regardless of bus remote mode
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_b;
  logic [NPIN-1:0] pin_fire;
  // One vector, so every pin gets the very same qualifier
  assign pin_b = {return_input_b, step_down_input_b, step_up_input_b};
  genvar pi;
  generate
    for (pi = 0; pi < NPIN; pi++) begin : g_pin
      prr_sync #(.HOLD(HOLD)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .pin_b(pin_b[pi]),
        .fire(pin_fire[pi])
      );
    end
  endgenerate
  assign up_fire = pin_fire[0];
  assign dn_fire = pin_fire[1];
  assign ret_fire = pin_fire[2];

  // ==========================================================
  // Recall sequencing
  assign g_begin = begin_q[act_grp_q];
  assign g_end = end_q[act_grp_q];
  // Stepping saturates at the group ends rather than wrapping
  assign up_idx = (pos_q >= g_end) ? g_end : pos_q + 1'b1;
  assign dn_idx = (pos_q <= g_begin) ? g_begin : pos_q - 1'b1;

  always_comb begin
    tgt_idx = pos_q;
    if (ret_fire) begin
      tgt_idx = g_begin;
    end else if (up_fire) begin
      tgt_idx = up_idx;
    end else if (dn_fire) begin
      tgt_idx = dn_idx;
    end else if (recall_req) begin
      tgt_idx = pwdata[PRR_IDX_W-1:0];
    end
  end

  // Front-panel recall needs a confirmed address; pins act directly
  logic any_req;
  logic in_range;
  assign busy = (state_q != PRR_IDLE);
  assign any_req = ret_fire || up_fire || dn_fire || recall_ok;
  assign in_range = (tgt_idx >= g_begin) && (tgt_idx <= g_end) && (int'(tgt_idx) < NPRE);
  assign start_rd = any_req && in_range && !busy;
  assign cancel_ev = any_req && !in_range;

  // Requests during an active read are dropped; pins are a second apart anyway
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= PRR_IDLE;
      pos_q <= '0;
      rd_idx_q <= '0;
      recall_valid <= 1'b0;
      recall_cond <= PRR_ZERO;
      last_rd_q <= PRR_ZERO;
    end else begin
      recall_valid <= 1'b0;
      unique case (state_q)
        PRR_IDLE: begin
          if (start_rd) begin
            rd_idx_q <= tgt_idx;
            pos_q <= tgt_idx;
            state_q <= PRR_READ;
          end
        end
        PRR_READ: state_q <= PRR_DONE;
        PRR_DONE: begin
          recall_cond <= mem_rd;
          last_rd_q <= mem_rd;
          recall_valid <= 1'b1;
          state_q <= PRR_IDLE;
        end
      endcase
    end
  end

  prr_mem #(.DEPTH(NPRE)) u_mem (
    .clock(clock),
    .wr_en(store_ok),
    .wr_addr(pwdata[PRR_IDX_W-1:0]),
    .wr_data(cond_q),
    .rd_addr(rd_idx_q),
    .rd_data(mem_rd)
  );

  // ==========================================================
  // Judgement and alarm pins
  // Upper is the smaller ratio; both bounds count as inside
  assign ber_ge_upper = (ber_q >= upper_q);
  assign ber_le_lower = (ber_q <= lower_q);
  assign alarm_any = |alarm_src_q;
  logic pass_now;
  assign pass_now = ber_ge_upper && ber_le_lower;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pass_out <= 1'b0;
      pass_out_b <= 1'b1;
      fail_out <= 1'b0;
      fail_out_b <= 1'b1;
      alarm_out <= 1'b0;
      alarm_oe_b <= 1'b1;
    end else begin
      pass_out <= pass_now;
      pass_out_b <= !pass_now;
      fail_out <= !pass_now;
      fail_out_b <= pass_now;
      alarm_out <= 1'b0;
      alarm_oe_b <= !alarm_any;
    end
  end

  // ==========================================================
  // Interrupts; a new event beats a same-cycle clear
  assign ev_recall = (state_q == PRR_DONE);
  assign ev_cancel = cancel_ev;
  assign ev_store = store_ok;
  always_comb begin
    ev = '0;
    ev[PRR_EV_RECALL] = ev_recall;
    ev[PRR_EV_CANCEL] = ev_cancel;
    ev[PRR_EV_STORE] = ev_store;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_st_q <= '0;
      irq <= 1'b0;
    end else begin
      if (clr_wr) begin
        irq_st_q <= (irq_st_q & ~pwdata[PRR_NUM_EV-1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      irq <= |(irq_st_q & irq_en_q);
    end
  end
endmodule

// ### hw/prr_pkg.sv
// Package for the preset recall remote port: constants, offsets and rule summary
// Summary of operation
// - Store up to 100 numbered setting conditions; write and read them back.
// - Up to ten groups, each with its own begin and end preset number.
// - A request outside the active group's range is cancelled, nothing recalled.
// - Step-up or step-down recalls next or previous preset within the group.
// - Return moves to the group's first preset and recalls it.
// - Step and return inputs are active low, pulled high when undriven.
// - Pass and fail results each driven active high and active low.
// - Alarm is OR of three alarms, active low, open-collector style.
// - Remote port stays active while under bus or network remote control.
// - Store key writes the condition to the selected, confirmed preset number.
// - Recall key restores the condition at the selected, confirmed preset number.
// - Pass when error ratio lies between thresholds, fail otherwise.
package prr_pkg;
  localparam int PRR_NUM_PRESETS = 100;
  localparam int PRR_NUM_GROUPS = 10;
  localparam int PRR_IDX_W = 7;
  localparam int PRR_GRP_W = 4;
  localparam int PRR_COND_W = 32;
  localparam int PRR_CLK_MHZ = 200;
  localparam int PRR_HOLD_MS = 1000;
  localparam int PRR_HOLD_CYCLES = PRR_HOLD_MS * 1000 * PRR_CLK_MHZ;
  localparam int PRR_CNT_W = 28;
  // Register byte offsets
  localparam logic [11:0] PRR_ADDR_CTRL = 12'h000;
  localparam logic [11:0] PRR_ADDR_STATUS = 12'h004;
  localparam logic [11:0] PRR_ADDR_COND = 12'h008;
  localparam logic [11:0] PRR_ADDR_RDATA = 12'h00C;
  localparam logic [11:0] PRR_ADDR_GROUP = 12'h010;
  localparam logic [11:0] PRR_ADDR_BER = 12'h014;
  localparam logic [11:0] PRR_ADDR_UPPER = 12'h018;
  localparam logic [11:0] PRR_ADDR_LOWER = 12'h01C;
  localparam logic [11:0] PRR_ADDR_ALARM = 12'h020;
  localparam logic [11:0] PRR_ADDR_IRQ_ST = 12'h024;
  localparam logic [11:0] PRR_ADDR_IRQ_EN = 12'h028;
  localparam logic [11:0] PRR_ADDR_IRQ_CLR = 12'h02C;
  // CTRL fields: [6:0] address, [7] confirm, [8] store, [9] recall, [13:10] active group
  localparam int PRR_CTRL_CONFIRM = 7;
  localparam int PRR_CTRL_STORE = 8;
  localparam int PRR_CTRL_RECALL = 9;
  localparam int PRR_CTRL_GRP_LSB = 10;
  // GROUP register: [3:0] group, [14:8] begin, [22:16] end
  localparam int PRR_GRP_BEGIN_LSB = 8;
  localparam int PRR_GRP_END_LSB = 16;
  // Interrupt event bits
  localparam int PRR_EV_RECALL = 0;
  localparam int PRR_EV_CANCEL = 1;
  localparam int PRR_EV_STORE = 2;
  localparam int PRR_NUM_EV = 3;
  localparam int PRR_NUM_ALARMS = 3;
  localparam logic [31:0] PRR_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {PRR_IDLE, PRR_READ, PRR_DONE} prr_state_type;
endpackage

// ### hw/prr_mem.sv
// Preset condition memory with registered read data
`timescale 1ns/100ps
module prr_mem
  import prr_pkg::*;
#(
  parameter int DEPTH = PRR_NUM_PRESETS,
  parameter int WIDTH = PRR_COND_W,
  parameter int AW = PRR_IDX_W
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ### hw/prr_sync.sv
// Three-stage synchroniser and one-second qualifier for an active-low remote input
`timescale 1ns/100ps
module prr_sync
  import prr_pkg::*;
#(
  parameter int HOLD = PRR_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pin_b,
  output logic fire
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [PRR_CNT_W-1:0] cnt_q;
  logic done_q;

  // Reset to high: an undriven pin reads idle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_b;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Act once per held assertion; release must be seen before the next
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!s2_q && !s3_q) begin
        if (!done_q) begin
          if (cnt_q >= PRR_CNT_W'(HOLD - 1)) begin
            fire <= 1'b1;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end else if (s2_q && s3_q) begin
        cnt_q <= '0;
        done_q <= 1'b0;
      end
    end
  end
endmodule

// ### dv/prr_props.sv
// Checker of the preset recall port outputs
`timescale 1ns/100ps
module prr_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pass_out,
  input wire logic pass_out_b,
  input wire logic fail_out,
  input wire logic fail_out_b,
  input wire logic alarm_out,
  input wire logic alarm_oe_b,
  input wire logic recall_valid,
  input wire logic irq
);
  // ==========================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd0;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_rd0: assert property (p_rd0) else $error("refused read not zero");
  property p_pass_pol;
    pass_out_b == !pass_out;
  endproperty
  a_pass_pol: assert property (p_pass_pol) else $error("pass copies differ");
  property p_fail_pol;
    fail_out_b == !fail_out;
  endproperty
  a_fail_pol: assert property (p_fail_pol) else $error("fail copies differ");
  // Judgement settles two cycles after reset
  property p_judge;
    $past(rst_b, 2) |-> pass_out != fail_out;
  endproperty
  a_judge: assert property (p_judge) else $error("pass and fail agree");
  property p_alarm;
    alarm_out == 1'b0;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm data high");
  property p_pulse;
    recall_valid |=> !recall_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("recall pulse long");
  c_recall: cover property (recall_valid);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
  c_alarm: cover property (!alarm_oe_b);
endmodule
bind prr_top prr_props i_props (.clock, .rst_b, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .pass_out, .pass_out_b, .fail_out, .fail_out_b, .alarm_out, .alarm_oe_b,
  .recall_valid, .irq);

// ### dv/prr_ctl.sv
// Model of the external controller on the remote pins
`timescale 1ns/100ps
module prr_ctl #(
  parameter int HOLD = 20
) (
  input wire logic clock,
  output logic step_up_input_b,
  output logic step_down_input_b,
  output logic return_input_b
);
  // ==========================================
  // Pins, released lines read high via pull-ups
  logic [2:0] pin_b = 3'h7;
  assign step_up_input_b = pin_b[0];
  assign step_down_input_b = pin_b[1];
  assign return_input_b = pin_b[2];
  // k: 0 up, 1 down, 2 return; never held below HOLD plus sync delay
  task press(input int k, input int extra);
    @(posedge clock);
    pin_b[k] <= 1'b0;
    repeat (HOLD + 8 + extra) @(posedge clock);
    pin_b <= 3'h7;
    repeat (2 * HOLD) @(posedge clock);
  endtask
endmodule

// ### dv/tb.sv
// Testbench of the preset recall remote port
`timescale 1ns/100ps
module tb;
  import prr_pkg::*;
  localparam int HOLD = 20;
  logic clock = 0;
  logic rst_b = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, recall_cond, rd, last;
  logic pready, pslverr, err, pass_out, pass_out_b, fail_out, fail_out_b;
  logic alarm_out, alarm_oe_b, recall_valid, irq;
  logic step_up_input_b, step_down_input_b, return_input_b;
  logic [31:0] mem [100];
  int fail_count = 0;
  int checks_done = 0;
  int nrv = 0;
  int n0, pos, k, ber, exp_p;
  int bgn = 20;
  int fin = 24;
  int bv [4] = '{3, 4, 11, 12};
  prr_top #(.HOLD(HOLD)) i_dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .step_up_input_b, .step_down_input_b, .return_input_b,
    .pass_out, .pass_out_b, .fail_out, .fail_out_b, .alarm_out, .alarm_oe_b, .recall_valid,
    .recall_cond, .irq);
  prr_ctl #(.HOLD(HOLD)) i_ctl (.clock, .step_up_input_b, .step_down_input_b,
    .return_input_b);
  always #2.5 clock = ~clock;
  // Mid-cycle look, so the one-cycle pulse is never raced by its own edge
  always @(negedge clock) begin
    if (recall_valid === 1'b1) begin
      nrv <= nrv + 1;
      last <= recall_cond;
    end
  end
  // ==========================================
  // Tasks
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // Ready and data seen mid-cycle are what the next rising edge samples
    do begin
      @(negedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // op 1 store, 2 recall; group 3 stays active
  task ctrl(input int idx, input logic [31:0] op);
    apb(1, PRR_ADDR_CTRL, (32'h0000_0003 << PRR_CTRL_GRP_LSB) | (op << PRR_CTRL_STORE) |
      (32'h0000_0001 << PRR_CTRL_CONFIRM) | 32'(idx));
    repeat (6) @(posedge clock);
  endtask
  // ==========================================
  // Watchdog
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    end_of_test;
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(95085));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    chk("pass", 1, pass_out);
    chk("alarm_oe_b", 1, alarm_oe_b);
    chk("irq", 0, irq);
    apb(1, PRR_ADDR_GROUP, 32'h0000_0003 | (fin << 16) | (bgn << 8));
    apb(1, PRR_ADDR_IRQ_EN, 32'h0000_0007);
    for (int i = bgn; i <= fin; i++) begin
      mem[i] = $urandom;
      apb(1, PRR_ADDR_COND, mem[i]);
      ctrl(i, 1);
    end
    for (int i = bgn; i <= fin; i++) begin
      ctrl(i, 2);
      chk("recall_cond", mem[i], last);
      apb(0, PRR_ADDR_RDATA, 0);
      chk("rdata", mem[i], rd);
    end
    n0 = nrv;
    ctrl(fin + 6, 2);
    chk("cancel", n0, nrv);
    apb(0, PRR_ADDR_IRQ_ST, 0);
    chk("irq_status", 32'h0000_0007, rd);
    chk("irq", 1, irq);
    apb(1, PRR_ADDR_IRQ_CLR, 32'h0000_0007);
    repeat (3) @(posedge clock);
    chk("irq", 0, irq);
    apb(1, PRR_ADDR_IRQ_EN, 32'h0000_0001);
    ctrl(bgn - 1, 2);
    chk("irq", 0, irq);
    ctrl(bgn, 2);
    chk("irq", 1, irq);
    apb(0, 12'h040, 0);
    chk("pslverr", 1, err);
    chk("unmapped", 0, rd);
    // Return first, then saturate both ends, then random
    for (int i = 0; i < 22; i++) begin
      k = (i == 0) ? 2 : (i < 7) ? 0 : (i < 13) ? 1 : $urandom_range(0, 2);
      pos = (k == 2) ? bgn : (k == 0) ? ((pos < fin) ? pos + 1 : fin) :
        ((pos > bgn) ? pos - 1 : bgn);
      n0 = nrv;
      i_ctl.press(k, $urandom_range(0, 2 * HOLD));
      chk("fires", n0 + 1, nrv);
      chk("pin_cond", mem[pos], last);
    end
    apb(0, PRR_ADDR_STATUS, 0);
    chk("status", 32'(pos), rd);
    apb(0, PRR_ADDR_GROUP, 0);
    chk("group", 32'h0000_0003 | (fin << 16) | (bgn << 8), rd);
    apb(1, PRR_ADDR_UPPER, 4);
    apb(1, PRR_ADDR_LOWER, 11);
    for (int i = 0; i < 10; i++) begin
      ber = (i < 4) ? bv[i] : $urandom_range(0, 15);
      exp_p = (ber >= 4 && ber <= 11);
      apb(1, PRR_ADDR_BER, ber);
      repeat (3) @(posedge clock);
      chk("pass", exp_p, pass_out);
      chk("fail_b", exp_p, fail_out_b);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, PRR_ADDR_ALARM, (i < 3) ? (1 << i) : 0);
      repeat (3) @(posedge clock);
      chk("alarm_oe_b", i == 3, alarm_oe_b);
    end
    end_of_test;
  end
endmodule
